// ---- gsf_framer.sv ----
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - alarm output stays low while not in alarm.
// - alarm goes high after gas above alarm value for five seconds.
// - alarm clears after gas at or below half alarm value five seconds.
// - one automatic status frame per sampling period at 9600 baud.
// - automatic frame is eighteen bytes, checksum last.
// - automatic frame equals the full status query reply.
// - bytes six to ten: state, gas, alarm value, preheat, calibration timer.
// - then reference high, low, year, month, day, version high, low.
// - state byte bits: preheat 0, alarm 2, fault 3, calib 4, uncal 5, standby 6.
// - reference reading is twelve bits right aligned, upper nibble zero.
// - date and version bytes are packed BCD.
// - checksum is two's complement of the byte sum, frame sums to zero.
// - automatic frame checksum covers the first seventeen bytes.
// - reply is header, length, type, version, instruction, data (full status reply only), checksum.
// - length byte counts every reply byte inclusive.
// - reply echoes the command instruction byte.
// - receive line idles high; a falling edge starts reception.
// - characters are start, data, stop bits at 9600 baud.
// - instruction ac address 00 returns the automatic frame content.
module gsf_framer #(
    parameter int         BIT_CYCLES    = gsf_pkg::BIT_CYC,
    parameter int         QUAL_CYCLES   = gsf_pkg::QUAL_CYC,
    parameter int         PERIOD_CYCLES = gsf_pkg::PERIOD_CYC,
    parameter logic [7:0] DEV_TYPE      = 8'h5a,   // arbitrary
    parameter logic [7:0] PROTO_VER     = 8'h3c    // arbitrary
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire gsf_pkg::gsf_apb_req_s apb_i,
    output var  gsf_pkg::gsf_apb_rsp_s apb_o,
    input  wire logic                  rx_i,
    output var  logic                  tx_o,
    output var  logic                  alarm_o
);
    import gsf_pkg::*;

    // device type and protocol version defaults are arbitrary
    localparam logic [31:0] BIT_M1  = 32'(BIT_CYCLES - 1);
    localparam logic [31:0] HALF_M1 = 32'(BIT_CYCLES / 2 - 1);
    localparam logic [31:0] QUAL_M1 = 32'(QUAL_CYCLES - 1);
    localparam logic [31:0] PER_M1  = 32'(PERIOD_CYCLES - 1);

    gsf_st_s q;
    gsf_st_s n;

    function automatic logic [7:0] to_bcd(input logic [7:0] v);
        logic [7:0] t;
        t = (v > BCD_MAX) ? BCD_MAX : v;
        return {4'(t / TEN), 4'(t % TEN)};
    endfunction

    function automatic logic [7:0] state_byte(input gsf_st_s s);
        logic [7:0] b;
        b = s.state_sw & STATE_SW_MSK;
        b[ST_ALARM] = s.alarm;
        return b;
    endfunction

    // payload byte at index for status or short reply
    function automatic logic [7:0] frame_byte(input gsf_st_s s, input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            8'd0:    b = HDR;
            8'd1:    b = s.tfull ? LEN_STATUS : LEN_SHORT;
            8'd2:    b = DEV_TYPE;
            8'd3:    b = PROTO_VER;
            8'd4:    b = s.tinstr;
            8'd5:    b = state_byte(s);
            8'd6:    b = s.gas;
            8'd7:    b = s.alarm_val;
            8'd8:    b = s.preheat;
            8'd9:    b = s.cal_tmr;
            8'd10:   b = {4'h0, s.vref[11:8]};
            8'd11:   b = s.vref[7:0];
            8'd12:   b = to_bcd(s.year);
            8'd13:   b = to_bcd(s.month);
            8'd14:   b = to_bcd(s.day);
            8'd15:   b = to_bcd(s.ver_hi);
            8'd16:   b = to_bcd(s.ver_lo);
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        logic [7:0] b;
        logic       cond;
        logic [7:0] csum;
        logic       tick;
        b = 8'h00;
        cond = 1'b0;
        tick = 1'b0;
        csum = 8'h00;
        n = q;

        // apb slave: answer one cycle after setup
        n.apb.pready = 1'b0;
        n.apb.pslverr = 1'b0;
        if (apb_i.psel && !apb_i.penable) begin
            n.apb.pready = 1'b1;
            n.apb.prdata = 32'h0;
            unique case (apb_i.paddr)
                OFF_CTRL:   n.apb.prdata = {31'h0, q.auto_en};
                OFF_GAS:    n.apb.prdata = {24'h0, q.gas};
                OFF_ALARM:  n.apb.prdata = {24'h0, q.alarm_val};
                OFF_TIMERS: n.apb.prdata = {16'h0, q.cal_tmr, q.preheat};
                OFF_STATE:  n.apb.prdata = {24'h0, state_byte(q)};
                OFF_VREF:   n.apb.prdata = {20'h0, q.vref};
                OFF_DATE:   n.apb.prdata = {8'h0, q.year, q.month, q.day};
                OFF_VER:    n.apb.prdata = {16'h0, q.ver_hi, q.ver_lo};
                OFF_STAT:   n.apb.prdata = {8'h0, q.cmd_addr, q.cmd_instr, 4'h0,
                                            q.tst != TX_IDLE, q.rep_pend, q.auto_pend, q.alarm};
                default:    n.apb.pslverr = 1'b1;
            endcase
        end
        if (apb_i.psel && apb_i.penable && q.apb.pready && apb_i.pwrite) begin
            unique case (apb_i.paddr)
                OFF_CTRL:   n.auto_en = apb_i.pwdata[0];
                OFF_GAS:    n.gas = apb_i.pwdata[7:0];
                OFF_ALARM:  n.alarm_val = apb_i.pwdata[7:0];
                OFF_TIMERS: {n.cal_tmr, n.preheat} = apb_i.pwdata[15:0];
                OFF_STATE:  n.state_sw = apb_i.pwdata[7:0] & STATE_SW_MSK;
                OFF_VREF:   n.vref = apb_i.pwdata[11:0];
                OFF_DATE:   {n.year, n.month, n.day} = apb_i.pwdata[23:0];
                OFF_VER:    {n.ver_hi, n.ver_lo} = apb_i.pwdata[15:0];
                default:    n.auto_en = q.auto_en;
            endcase
        end

        // alarm qualification with hysteresis
        if (!q.alarm) begin
            cond = q.gas > q.alarm_val;
        end else begin
            cond = q.gas <= {1'b0, q.alarm_val[7:1]};
        end
        if (cond) begin
            if (q.qual_cnt >= QUAL_M1) begin
                n.alarm = !q.alarm;
                n.qual_cnt = 32'h0;
            end else begin
                n.qual_cnt = q.qual_cnt + 32'h1;
            end
        end else begin
            n.qual_cnt = 32'h0;
        end

        // sampling period tick
        if (q.per_cnt >= PER_M1) begin
            n.per_cnt = 32'h0;
            if (q.auto_en) begin
                n.auto_pend = 1'b1;
                tick = 1'b1;
            end
        end else begin
            n.per_cnt = q.per_cnt + 32'h1;
        end

        // transmitter
        unique case (q.tst)
            TX_IDLE: begin
                n.tx = 1'b1;
                n.tbaud = 32'h0;
                if (q.rep_pend || q.auto_pend) begin
                    if (q.rep_pend) begin
                        n.rep_pend = 1'b0;
                        n.tfull = q.rep_full;
                        n.tinstr = q.rep_instr;
                    end else begin
                        n.auto_pend = tick;        // a new tick wins over the take
                        n.tfull = 1'b1;
                        n.tinstr = CMD_FULL;
                    end
                    n.tlen = n.tfull ? LEN_STATUS : LEN_SHORT;
                    n.tidx = 8'h0;
                    b = HDR;
                    n.tsh = b;
                    n.tsum = b;
                    n.tst = TX_START;
                end
            end
            TX_START: begin
                n.tx = 1'b0;
                if (q.tbaud >= BIT_M1) begin
                    n.tbaud = 32'h0;
                    n.tbit = 3'h0;
                    n.tst = TX_DATA;
                end else begin
                    n.tbaud = q.tbaud + 32'h1;
                end
            end
            TX_DATA: begin
                n.tx = q.tsh[q.tbit];
                if (q.tbaud >= BIT_M1) begin
                    n.tbaud = 32'h0;
                    n.tbit = q.tbit + 3'h1;
                    if (q.tbit == 3'h7) begin
                        n.tst = TX_STOP;
                    end
                end else begin
                    n.tbaud = q.tbaud + 32'h1;
                end
            end
            TX_STOP: begin
                n.tx = 1'b1;
                if (q.tbaud >= BIT_M1) begin
                    n.tbaud = 32'h0;
                    if (q.tidx + 8'h1 < q.tlen) begin
                        n.tidx = q.tidx + 8'h1;
                        if (n.tidx == q.tlen - 8'h1) begin
                            b = 8'h0 - q.tsum;
                        end else begin
                            b = frame_byte(q, n.tidx);
                        end
                        n.tsh = b;
                        n.tsum = q.tsum + b;
                        n.tst = TX_START;
                    end else begin
                        n.tst = TX_IDLE;
                    end
                end else begin
                    n.tbaud = q.tbaud + 32'h1;
                end
            end
            default: begin
                n.tx = 1'b1;
                n.tst = TX_IDLE;
            end
        endcase

        // receiver
        n.rprev = rx_i;
        unique case (q.rst)
            RX_IDLE: begin
                n.rbaud = 32'h0;
                if (q.rprev && !rx_i) begin
                    n.rst = RX_START;
                end
            end
            RX_START: begin
                if (q.rbaud >= HALF_M1) begin
                    n.rbaud = 32'h0;
                    n.rbit = 3'h0;
                    n.rst = rx_i ? RX_IDLE : RX_DATA;
                end else begin
                    n.rbaud = q.rbaud + 32'h1;
                end
            end
            RX_DATA: begin
                if (q.rbaud >= BIT_M1) begin
                    n.rbaud = 32'h0;
                    n.rsh = {rx_i, q.rsh[7:1]};
                    n.rbit = q.rbit + 3'h1;
                    if (q.rbit == 3'h7) begin
                        n.rst = RX_STOP;
                    end
                end else begin
                    n.rbaud = q.rbaud + 32'h1;
                end
            end
            RX_STOP: begin
                if (q.rbaud >= BIT_M1) begin
                    n.rbaud = 32'h0;
                    n.rst = RX_IDLE;
                    if (rx_i) begin
                        csum = q.rsum + q.rsh;
                        n.rsum = csum;
                        n.rcnt = q.rcnt + 2'h1;
                        if (q.rcnt == 2'h0) begin
                            n.cmd_instr = q.rsh;
                        end
                        if (q.rcnt == 2'h1) begin
                            n.cmd_addr = q.rsh;
                        end
                        if (q.rcnt == CMD_LAST) begin
                            n.rsum = 8'h0;
                            if (csum == 8'h0) begin
                                n.rep_pend = 1'b1;
                                n.rep_instr = q.cmd_instr;
                                n.rep_full = q.cmd_instr == CMD_FULL
                                             && q.cmd_addr == ADDR_FULL;
                            end
                        end
                    end else begin
                        n.rcnt = 2'h0;
                        n.rsum = 8'h0;
                    end
                end else begin
                    n.rbaud = q.rbaud + 32'h1;
                end
            end
            default: n.rst = RX_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.tst <= TX_IDLE;
            q.rst <= RX_IDLE;
            q.tx <= 1'b1;
            q.rprev <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign apb_o = q.apb;
    assign tx_o = q.tx;
    assign alarm_o = q.alarm;
endmodule
`default_nettype wire

// ---- gsf_framer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsf_framer_chk #(
    parameter int BIT_CYCLES  = 8,
    parameter int QUAL_CYCLES = 50
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire gsf_pkg::gsf_apb_req_s apb_i,
    input wire gsf_pkg::gsf_apb_rsp_s apb_o,
    input wire logic                  rx_i,
    input wire logic                  tx_o,
    input wire logic                  alarm_o
);
    import gsf_pkg::*;
    logic [7:0]  gas_q;
    logic [7:0]  alv_q;
    logic [31:0] hi_q;
    logic [31:0] lo_q;
    logic        wr;
    assign wr = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite;
    // shadow of gas and limit, run length of each alarm condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gas_q <= '0;
            alv_q <= '0;
            hi_q  <= '0;
            lo_q  <= '0;
        end else begin
            if (wr && apb_i.paddr == OFF_GAS) gas_q <= apb_i.pwdata[7:0];
            if (wr && apb_i.paddr == OFF_ALARM) alv_q <= apb_i.pwdata[7:0];
            hi_q <= (gas_q > alv_q) ? hi_q + 1 : '0;
            lo_q <= (gas_q <= (alv_q >> 1)) ? lo_q + 1 : '0;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_bit_low;
        (!tx_o) [*8];
    endsequence
    property p_rst_idle;
        $rose(presetn) |-> tx_o && !alarm_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    property p_alarm_set;
        $rose(alarm_o) |-> hi_q >= QUAL_CYCLES - 4;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm rose too early");
    property p_alarm_late;
        hi_q > QUAL_CYCLES + 4 |-> alarm_o;
    endproperty
    a_alarm_late: assert property (p_alarm_late) else $error("alarm did not rise");
    property p_alarm_clr;
        $fell(alarm_o) |-> lo_q >= QUAL_CYCLES - 4;
    endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("alarm fell too early");
    property p_alarm_hold;
        lo_q > QUAL_CYCLES + 4 |-> !alarm_o;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm did not clear");
    property p_tx_start;
        $fell(tx_o) |-> s_bit_low;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("low bit shorter than a bit time");
    property p_ready;
        s_setup |=> apb_o.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access cycle");
    property p_unmapped;
        s_setup ##0 apb_i.paddr > OFF_STAT |=> apb_o.pslverr && apb_o.prdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ---- gsf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gsf_host_model #(
    parameter int BIT = 8
) (
    input  wire logic pclk,
    input  wire logic tx_line,
    output var  logic rx_line
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    initial rx_line = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask
    task automatic send_cmd(input logic [7:0] ins, input logic [7:0] adr, input logic [7:0] dat, input logic bad);
        logic [7:0] ck;
        ck = 8'h00 - ins - adr - dat + {7'h00, bad};
        send_byte(ins);
        send_byte(adr);
        send_byte(dat);
        send_byte(ck);
    endtask
    // mid-bit sampling of the device transmit line
    always @(negedge tx_line) begin
        repeat (BIT + BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            sh[i] = tx_line;
            repeat (BIT) @(posedge pclk);
        end
        if (tx_line === 1'b1) got_q.push_back(sh);
    end
endmodule
`default_nettype wire

// ---- gsf_pkg.sv ----
`default_nettype none
package gsf_pkg;
    // timing
    localparam int CLK_HZ          = 200_000_000;
    localparam int BAUD            = 9600;
    localparam int ALARM_QUAL_S    = 5;
    localparam int SAMPLE_PERIOD_S = 1;
    localparam int BIT_CYC         = CLK_HZ / BAUD;
    localparam int QUAL_CYC        = ALARM_QUAL_S * CLK_HZ;
    localparam int PERIOD_CYC      = SAMPLE_PERIOD_S * CLK_HZ;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_GAS    = 12'h004;
    localparam logic [11:0] OFF_ALARM  = 12'h008;
    localparam logic [11:0] OFF_TIMERS = 12'h00c;
    localparam logic [11:0] OFF_STATE  = 12'h010;
    localparam logic [11:0] OFF_VREF   = 12'h014;
    localparam logic [11:0] OFF_DATE   = 12'h018;
    localparam logic [11:0] OFF_VER    = 12'h01c;
    localparam logic [11:0] OFF_STAT   = 12'h020;

    // frame constants
    localparam logic [7:0] HDR          = 8'haa;
    localparam logic [7:0] CMD_FULL     = 8'hac;
    localparam logic [7:0] ADDR_FULL    = 8'h00;
    localparam logic [7:0] LEN_STATUS   = 8'h12;
    localparam logic [7:0] LEN_SHORT    = 8'h06;
    localparam logic [1:0] CMD_LAST     = 2'h3;
    localparam logic [7:0] STATE_SW_MSK = 8'h79;
    localparam int         ST_ALARM     = 2;
    localparam logic [7:0] BCD_MAX      = 8'h63;
    localparam logic [7:0] TEN          = 8'h0a;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } gsf_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gsf_apb_rsp_s;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } gsf_tx_e;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } gsf_rx_e;

    typedef struct packed {
        gsf_apb_rsp_s apb;
        logic         auto_en;
        logic [7:0]   gas;
        logic [7:0]   alarm_val;
        logic [7:0]   preheat;
        logic [7:0]   cal_tmr;
        logic [7:0]   state_sw;
        logic [11:0]  vref;
        logic [7:0]   year;
        logic [7:0]   month;
        logic [7:0]   day;
        logic [7:0]   ver_hi;
        logic [7:0]   ver_lo;
        logic         alarm;
        logic [31:0]  qual_cnt;
        logic [31:0]  per_cnt;
        logic         auto_pend;
        logic         rep_pend;
        logic         rep_full;
        logic [7:0]   rep_instr;
        gsf_tx_e      tst;
        logic [31:0]  tbaud;
        logic [2:0]   tbit;
        logic [7:0]   tsh;
        logic [7:0]   tidx;
        logic [7:0]   tlen;
        logic [7:0]   tsum;
        logic         tfull;
        logic [7:0]   tinstr;
        logic         tx;
        gsf_rx_e      rst;
        logic [31:0]  rbaud;
        logic [2:0]   rbit;
        logic [7:0]   rsh;
        logic         rprev;
        logic [1:0]   rcnt;
        logic [7:0]   rsum;
        logic [7:0]   cmd_instr;
        logic [7:0]   cmd_addr;
    } gsf_st_s;
endpackage
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gsf_pkg::*;
    localparam int         BITC  = 8;
    localparam int         QUAL  = 50;
    localparam int         PER   = 2000;
    localparam logic [7:0] DTYPE = 8'h5a; // arbitrary
    localparam logic [7:0] PVER  = 8'h3c; // arbitrary
    logic         pclk;
    logic         presetn;
    gsf_apb_req_s req;
    gsf_apb_rsp_s rsp;
    logic         rx;
    logic         tx;
    logic         alarm;
    logic [31:0]  rd;
    logic         serr;
    int           err_total;
    int           checks_done;
    int           waited;
    int           exp_q[$];
    int           gas, alv, pre, cal, st, vref, yy, mo, dd, vh, vl, alm;
    logic [7:0]   cl[5] = '{8'haf, 8'had, 8'hd2, 8'he0, 8'hac};
    logic [7:0]   al[5] = '{8'h00, 8'h00, 8'h50, 8'h1b, 8'h01};
    gsf_framer #(
        .BIT_CYCLES   (BITC),
        .QUAL_CYCLES  (QUAL),
        .PERIOD_CYCLES(PER),
        .DEV_TYPE     (DTYPE),
        .PROTO_VER    (PVER)
    ) dut (
        .pclk   (pclk),
        .presetn(presetn),
        .apb_i  (req),
        .apb_o  (rsp),
        .rx_i   (rx),
        .tx_o   (tx),
        .alarm_o(alarm)
    );
    gsf_host_model #(.BIT(BITC)) host (
        .pclk   (pclk),
        .tx_line(tx),
        .rx_line(rx)
    );
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 50) chk("pready", 1, 0);
    endtask
    function automatic int bcd(input int v);
        int c;
        c = (v > 99) ? 99 : v;
        return (c / 10) * 16 + c % 10;
    endfunction
    task automatic mk(input int ins, input bit full);
        int s;
        s = 0;
        exp_q = {'haa, full ? 18 : 6, DTYPE, PVER, ins};
        if (full)
            exp_q = {exp_q, (st & 'h79) | (alm << 2), gas, alv, pre, cal, vref >> 8, vref & 'hff,
                     bcd(yy), bcd(mo), bcd(dd), bcd(vh), bcd(vl)};
        foreach (exp_q[i]) s += exp_q[i];
        exp_q.push_back((256 - s % 256) % 256);
    endtask
    task automatic rx_frame(input string nm);
        waited = 0;
        while (host.got_q.size() < exp_q.size() && waited < 3 * PER) begin
            @(posedge pclk);
            waited++;
        end
        chk(nm, exp_q.size(), host.got_q.size());
        foreach (exp_q[i]) chk(nm, exp_q[i], host.got_q[i]);
        host.got_q = {};
        $display("test %s done", nm);
    endtask
    task automatic query(input logic [7:0] i, input logic [7:0] a, input bit full, input string nm);
        host.send_cmd(i, a, 8'($urandom), 1'b0);
        mk(i, full);
        rx_frame(nm);
    endtask
    task automatic alarm_step(input int g, input int w, input logic e);
        gas = g;
        apb(1'b1, OFF_GAS, 32'(g));
        repeat (w) @(posedge pclk);
        chk("alarm", e, alarm);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        err_total = 0;
        checks_done = 0;
        void'($urandom(32'hca092539));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("alarm idle", 0, alarm);
        chk("tx idle", 1, tx);
        for (int a = 0; a <= 'h24; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk("reset read", 0, rd);
            chk("slverr", a == 'h24, serr);
        end
        $display("test reset done");
        gas = $urandom_range(0, 99);
        alv = 200;
        pre = $urandom_range(0, 255);
        cal = $urandom_range(0, 255);
        st = $urandom_range(0, 255);
        vref = $urandom_range(0, 4095);
        yy = $urandom_range(0, 120);
        mo = $urandom_range(1, 12);
        dd = $urandom_range(1, 31);
        vh = $urandom_range(0, 99);
        vl = $urandom_range(0, 99);
        alm = 0;
        apb(1'b1, OFF_GAS, 32'(gas));
        apb(1'b1, OFF_ALARM, 32'(alv));
        apb(1'b1, OFF_TIMERS, 32'(cal * 256 + pre));
        apb(1'b1, OFF_STATE, 32'(st));
        apb(1'b1, OFF_VREF, 32'(vref));
        apb(1'b1, OFF_DATE, 32'(yy * 65536 + mo * 256 + dd));
        apb(1'b1, OFF_VER, 32'(vh * 256 + vl));
        apb(1'b0, OFF_STATE, 32'h0);
        chk("state", (st & 'h79) | (alm << 2), rd);
        query(CMD_FULL, ADDR_FULL, 1'b1, "full status");
        foreach (cl[i]) query(cl[i], al[i], 1'b0, "short reply");
        host.send_cmd(CMD_FULL, ADDR_FULL, 8'h00, 1'b1);
        repeat (PER) @(posedge pclk);
        chk("bad frame reply", 0, host.got_q.size());
        apb(1'b0, OFF_STAT, 32'h0);
        chk("status", 32'h0000ac00, rd);
        $display("test bad frame done");
        alv = 100;
        apb(1'b1, OFF_ALARM, 32'(alv));
        alarm_step(100, QUAL + 20, 1'b0);
        alarm_step(101, QUAL - 5, 1'b0);
        repeat (10) @(posedge pclk);
        chk("alarm set", 1, alarm);
        alm = 1;
        query(CMD_FULL, ADDR_FULL, 1'b1, "alarm status");
        alarm_step(51, QUAL + 20, 1'b1);
        alarm_step(50, QUAL - 5, 1'b1);
        repeat (10) @(posedge pclk);
        chk("alarm clear", 0, alarm);
        $display("test alarm done");
        alm = 0;
        apb(1'b1, OFF_CTRL, 32'h1);
        mk(CMD_FULL, 1'b1);
        rx_frame("auto first");
        rx_frame("auto second");
        chk("period", 1, waited > PER - 100 && waited < PER + 100);
        apb(1'b1, OFF_CTRL, 32'h0);
        repeat (2 * PER) @(posedge pclk);
        chk("auto off", 0, host.got_q.size());
        $display("test auto off done");
        tally_and_finish();
    end
endmodule
bind gsf_framer gsf_framer_chk #(
    .BIT_CYCLES (BIT_CYCLES),
    .QUAL_CYCLES(QUAL_CYCLES)
) u_chk (
    .pclk   (pclk),
    .presetn(presetn),
    .apb_i  (apb_i),
    .apb_o  (apb_o),
    .rx_i   (rx_i),
    .tx_o   (tx_o),
    .alarm_o(alarm_o)
);
`default_nettype wire
